// ===== sfs_cfg.svh
// Constants of the chopped sinc and fast-settling decimation filter.
// Assumes nothing; it holds definitions only and is included by its name.
`ifndef SFS_CFG_SVH
`define SFS_CFG_SVH

// Register byte offsets.
`define SFS_REG_CONFIG       4'h0
`define SFS_REG_CHANNEL      4'h4
`define SFS_REG_STATUS       4'h8
`define SFS_REG_RESULT       4'hc

// Configuration word field positions.
`define SFS_CFG_RATE_LSB     0
`define SFS_CFG_RATE_MSB     9
`define SFS_CFG_AVG_LO_BIT   10
`define SFS_CFG_AVG_HI_BIT   11
`define SFS_CFG_CHOP_BIT     12
`define SFS_CFG_NOTCH_BIT    13

// Reset values.
`define SFS_RATE_RESET       10'h060
`define SFS_CHOP_RESET       1'b1
`define SFS_CHANNEL_RESET    4'h0

// Rate word limits.
`define SFS_RATE_MIN         10'h001
`define SFS_RATE_MAX         10'h3ff

// Timing constants: sub-period cycles per rate step and its shift, filter orders, chop settle conversions.
`define SFS_SUB_PERIOD_CYCLES 1024
`define SFS_SUB_SHIFT        10
`define SFS_SINC3_ORDER      5'h03
`define SFS_SINC4_ORDER      5'h04
`define SFS_CHOP_SETTLE_CONV 2

// Data widths.
`define SFS_DATA_W           28
`define SFS_CHAN_W           4

`endif

// ===== sfs_pkg.sv
// Types shared by the decimation filter, its checker, readout model and bench.
// Assumes the constants header is on the include path.
`include "sfs_cfg.svh"

package sfs_pkg;

    // Engine state, one-hot.
    typedef enum logic [1:0] {
        SFS_ST_RESET = 2'b01,
        SFS_ST_RUN   = 2'b10
    } sfs_state_e;

    // Filter configuration as software writes it.
    typedef struct packed {
        logic                      notch_60hz_enable;
        logic                      chop_enable;
        logic                      postfilter_avg_sel_hi;
        logic                      postfilter_avg_sel_lo;
        logic [9:0]                rate_divider_word;
    } sfs_cfg_s;

    // One conversion result on its way to the readout path.
    typedef struct packed {
        logic [`SFS_CHAN_W-1:0]    channel;
        logic [`SFS_DATA_W-1:0]    data;
    } sfs_result_s;

endpackage

// ===== sfs_skid.sv
// Two-entry buffer between the filter engine and the readout path.
// Assumes both sides follow valid and ready on the same clock.
`timescale 1ns/100ps

module sfs_skid #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 2
) (
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_q;
    logic [PW-1:0]    wr_d;
    logic [PW-1:0]    rd_q;
    logic [PW-1:0]    rd_d;
    logic [PW:0]      cnt_q;
    logic [PW:0]      cnt_d;
    logic             push;
    logic             pop;

    ////////////////////////////////////////////////////////////////////////
    // Handshakes are combinational; full and empty come from the count.
    assign in_ready  = (cnt_q != DEPTH[PW:0]);
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = ce && in_valid && in_ready;
    assign pop       = ce && out_valid && out_ready;

    // Pointer arithmetic wraps at the depth, which need not be a power of 2.
    always_comb begin
        wr_d  = wr_q;
        rd_d  = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            wr_d = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // Storage has no reset; only the count and pointers define what is valid.
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointer and count registers.
    always_ff @(posedge mclk) begin
        if (reset) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (ce) begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

endmodule

// ===== sfs_filter.sv
// Decimation filter control: chopped sinc3 and fast-settling sinc4 modes.
// Assumes the modulator bitstream arrives asynchronously on mod_bit, one
// sample per master clock, and that the readout path drains result_*.
`timescale 1ns/100ps
`include "sfs_cfg.svh"

module sfs_filter (
    input  wire logic                  mclk,
    input  wire logic                  reset,
    input  wire logic                  ce,
    input  wire logic [3:0]            reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_wstrb,
    input  wire logic                  reg_rstrb,
    output logic [31:0]                reg_rdata,
    input  wire logic                  mod_bit,
    output logic                       modulator_reset,
    output logic                       chop_swap,
    output logic                       result_valid,
    input  wire logic                  result_ready,
    output sfs_pkg::sfs_result_s       result_data
);
    import sfs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Decoding helpers.

    // Averaging factor of the postfilter; zero means fast settling is off.
    function automatic logic [4:0] avg_factor(input logic [1:0] sel);
        logic [4:0] f;
        f = 5'h00;
        unique case (sel)
            2'b00: f = 5'h00;
            2'b01: f = 5'h02;
            2'b10: f = 5'h08;
            2'b11: f = 5'h10;
        endcase
        return f;
    endfunction

    // Sub-periods in one conversion: 3 for sinc3, else sinc4 order plus postfilter length minus one.
    function automatic logic [4:0] subs_per_conv(input sfs_cfg_s c);
        logic [4:0] a;
        logic [4:0] n;
        a = avg_factor({c.postfilter_avg_sel_hi, c.postfilter_avg_sel_lo});
        n = `SFS_SINC3_ORDER;
        if (a != 5'h00) begin
            n = `SFS_SINC4_ORDER + a - 5'h01;
        end
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations.

    localparam int DW = `SFS_DATA_W;

    sfs_cfg_s          cfg_q;
    sfs_cfg_s          cfg_d;
    logic [3:0]        chan_q;
    logic [3:0]        chan_d;
    logic [31:0]       rdata_q;
    logic [31:0]       rdata_d;
    logic              mod_s1_q;
    logic              mod_s2_q;
    sfs_state_e        state_q;
    sfs_state_e        state_d;
    logic [19:0]       cyc_q;
    logic [19:0]       cyc_d;
    logic [4:0]        sub_q;
    logic [4:0]        sub_d;
    logic [DW-1:0]     acc_q;
    logic [DW-1:0]     acc_d;
    logic [DW-1:0]     prev_q;
    logic [DW-1:0]     prev_d;
    logic              have_prev_q;
    logic              have_prev_d;
    logic [DW-1:0]     last_q;
    logic [DW-1:0]     last_d;
    logic              have_last_q;
    logic              have_last_d;
    logic              pol_q;
    logic              pol_d;
    logic              settled_q;
    logic              settled_d;
    logic [7:0]        conv_cnt_q;
    logic [7:0]        conv_cnt_d;
    sfs_result_s       res_q;
    sfs_result_s       res_d;
    logic              res_vld_q;
    logic              res_vld_d;
    logic              buf_in_ready;
    logic              restart;
    logic              stall;
    logic              advance;
    logic [9:0]        fs_eff;
    logic [19:0]       cyc_limit;
    logic              sub_end;
    logic              conv_end;
    logic [DW-1:0]     delta;
    logic [DW-1:0]     conv_sum;
    logic [DW:0]       pair_sum;
    logic [DW:0]       notch_sum;
    logic [DW-1:0]     filtered;
    logic              emit;

    ////////////////////////////////////////////////////////////////////////
    // Register port. A write to CONFIG or CHANNEL restarts the engine.
    always_comb begin
        cfg_d   = cfg_q;
        chan_d  = chan_q;
        rdata_d = 32'h0000_0000;
        restart = 1'b0;
        if (reg_wstrb && reg_addr == `SFS_REG_CONFIG) begin
            cfg_d   = sfs_cfg_s'(reg_wdata[13:0]);
            restart = 1'b1;
        end
        if (reg_wstrb && reg_addr == `SFS_REG_CHANNEL) begin
            chan_d  = reg_wdata[3:0];
            restart = 1'b1;
        end
        if (reg_rstrb) begin
            unique case (reg_addr)
                `SFS_REG_CONFIG:  rdata_d = {18'h00000, cfg_q};
                `SFS_REG_CHANNEL: rdata_d = {28'h0000000, chan_q};
                `SFS_REG_STATUS:  rdata_d = {16'h0000, conv_cnt_q, 3'h0,
                                             modulator_reset, settled_q,
                                             pol_q, result_valid,
                                             res_vld_q};
                `SFS_REG_RESULT:  rdata_d = {{(32-DW){last_q[DW-1]}},
                                             last_q};
                default:          rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Register file flops; read data stands only in the cycle after rstrb.
    always_ff @(posedge mclk) begin
        if (reset) begin
            cfg_q   <= '{notch_60hz_enable:     1'b0,
                         chop_enable:           `SFS_CHOP_RESET,
                         postfilter_avg_sel_hi: 1'b0,
                         postfilter_avg_sel_lo: 1'b0,
                         rate_divider_word:     `SFS_RATE_RESET};
            chan_q  <= `SFS_CHANNEL_RESET;
            rdata_q <= 32'h0000_0000;
        end else if (ce) begin
            cfg_q   <= cfg_d;
            chan_q  <= chan_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Bitstream synchroniser; only the second stage feeds the filter.
    always_ff @(posedge mclk) begin
        if (reset) begin
            mod_s1_q <= 1'b0;
            mod_s2_q <= 1'b0;
        end else if (ce) begin
            mod_s1_q <= mod_bit;
            mod_s2_q <= mod_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timing decode. A zero word is taken as 1 so the divider never stalls.
    assign fs_eff    = (cfg_q.rate_divider_word < `SFS_RATE_MIN) ?
                       `SFS_RATE_MIN : cfg_q.rate_divider_word;
    assign cyc_limit = {fs_eff, 10'h000} - 20'h00001;
    assign sub_end   = (cyc_q == cyc_limit);
    assign conv_end  = sub_end && (sub_q == subs_per_conv(cfg_q) - 5'h01);

    // A pending result that the buffer refuses freezes the engine, so no
    // word is dropped except by a restart; the cost is a stretched conversion period.
    assign stall   = res_vld_q && !buf_in_ready;
    assign advance = (state_q == SFS_ST_RUN) && !stall;

    // Each modulator one counts up and each zero down; in the swapped
    // orientation the sign flips back so offset alternates in sign.
    assign delta    = (mod_s2_q ^ pol_q) ? {{(DW-1){1'b0}}, 1'b1}
                                         : {DW{1'b1}};
    assign conv_sum = acc_q + delta;

    // Chopped pairs are averaged, cancelling the offset of either leg.
    assign pair_sum  = {conv_sum[DW-1], conv_sum}
                     + {prev_q[DW-1], prev_q};

    // The notch option averages with the previous output at the same rate,
    // which places an extra zero near 60 Hz for the 96 and 16 settings.
    assign notch_sum = {filtered[DW-1], filtered}
                     + {last_q[DW-1], last_q};

    always_comb begin
        filtered = conv_sum;
        if (cfg_q.chop_enable) begin
            filtered = pair_sum[DW:1];
        end
    end

    // Unchopped results leave every conversion; chopped ones need a pair.
    assign emit = conv_end && advance &&
                  (!cfg_q.chop_enable || have_prev_q);

    ////////////////////////////////////////////////////////////////////////
    // Conversion engine next state.
    always_comb begin
        state_d     = state_q;
        cyc_d       = cyc_q;
        sub_d       = sub_q;
        acc_d       = acc_q;
        prev_d      = prev_q;
        have_prev_d = have_prev_q;
        last_d      = last_q;
        have_last_d = have_last_q;
        pol_d       = pol_q;
        settled_d   = settled_q;
        conv_cnt_d  = conv_cnt_q;
        res_d       = res_q;
        res_vld_d   = res_vld_q && !buf_in_ready;
        unique case (state_q)
            SFS_ST_RESET: begin
                // One cycle of modulator and filter reset.
                state_d = SFS_ST_RUN;
            end
            SFS_ST_RUN: begin
                if (advance) begin
                    // Results keep flowing whatever the input does.
                    cyc_d = sub_end ? 20'h00000 : cyc_q + 20'h00001;
                    acc_d = conv_sum;
                    if (sub_end) begin
                        sub_d = sub_q + 5'h01;
                    end
                    if (conv_end) begin
                        sub_d       = 5'h00;
                        acc_d       = '0;
                        prev_d      = conv_sum;
                        have_prev_d = 1'b1;
                        pol_d       = cfg_q.chop_enable ? !pol_q
                                                        : 1'b0;
                        conv_cnt_d  = conv_cnt_q + 8'h01;
                    end
                    if (emit) begin
                        // A partial result after an async step is output
                        // as is; the next window is clean.
                        res_d.channel = chan_q;
                        res_d.data    = filtered;
                        if (cfg_q.notch_60hz_enable && have_last_q) begin
                            res_d.data = notch_sum[DW:1];
                        end
                        last_d      = res_d.data;
                        have_last_d = 1'b1;
                        settled_d   = 1'b1;
                        res_vld_d   = 1'b1; // Set wins over acceptance.
                    end
                end
            end
        endcase
        if (restart) begin
            // Channel or setting change throws away all filter history.
            state_d     = SFS_ST_RESET;
            cyc_d       = 20'h00000;
            sub_d       = 5'h00;
            acc_d       = '0;
            have_prev_d = 1'b0;
            have_last_d = 1'b0;
            pol_d       = 1'b0;
            settled_d   = 1'b0;
            conv_cnt_d  = 8'h00;
            res_vld_d   = 1'b0;
        end
    end

    // Conversion engine registers.
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_q     <= SFS_ST_RESET;
            cyc_q       <= 20'h00000;
            sub_q       <= 5'h00;
            acc_q       <= '0;
            prev_q      <= '0;
            have_prev_q <= 1'b0;
            last_q      <= '0;
            have_last_q <= 1'b0;
            pol_q       <= 1'b0;
            settled_q   <= 1'b0;
            conv_cnt_q  <= 8'h00;
            res_q       <= '0;
            res_vld_q   <= 1'b0;
        end else if (ce) begin
            state_q     <= state_d;
            cyc_q       <= cyc_d;
            sub_q       <= sub_d;
            acc_q       <= acc_d;
            prev_q      <= prev_d;
            have_prev_q <= have_prev_d;
            last_q      <= last_d;
            have_last_q <= have_last_d;
            pol_q       <= pol_d;
            settled_q   <= settled_d;
            conv_cnt_q  <= conv_cnt_d;
            res_q       <= res_d;
            res_vld_q   <= res_vld_d;
        end
    end

    assign modulator_reset = (state_q == SFS_ST_RESET);
    assign chop_swap       = pol_q;

    ////////////////////////////////////////////////////////////////////////
    // Output buffer toward the readout path.
    sfs_skid #(
        .WIDTH ($bits(sfs_result_s)),
        .DEPTH (2)
    ) u_skid (
        .mclk      (mclk),
        .reset     (reset),
        .ce        (ce),
        .in_valid  (res_vld_q),
        .in_ready  (buf_in_ready),
        .in_data   (res_q),
        .out_valid (result_valid),
        .out_ready (result_ready),
        .out_data  (result_data)
    );

endmodule

// ===== sfs_filter_asserts.sv
// Port checker for the decimation filter, bound to every sfs_filter.
// Assumes sfs_pkg is compiled first and ce is held high by the bench.
`timescale 1ns/100ps

module sfs_filter_chk
(
    input wire logic                  mclk,
    input wire logic                  reset,
    input wire logic                  ce,
    input wire logic [3:0]            reg_addr,
    input wire logic [31:0]           reg_wdata,
    input wire logic                  reg_wstrb,
    input wire logic                  reg_rstrb,
    input wire logic [31:0]           reg_rdata,
    input wire logic                  mod_bit,
    input wire logic                  modulator_reset,
    input wire logic                  chop_swap,
    input wire logic                  result_valid,
    input wire logic                  result_ready,
    input wire sfs_pkg::sfs_result_s  result_data
);
    import sfs_pkg::*;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////////////
    // Read data must not linger, or software would see stale words.
    property p_rdata_idle;
        !reg_rstrb |=> reg_rdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside a read");

    // Status snapshot reflects the port state at the read edge.
    property p_status_snap;
        reg_rstrb && reg_addr == 4'h8 |=>
            reg_rdata[1] == $past(result_valid) &&
            reg_rdata[4] == $past(modulator_reset);
    endproperty
    a_status_snap: assert property (p_status_snap)
        else $error("status bits differ from port state");

    property p_rst_release;
        $fell(reset) |-> modulator_reset && !result_valid && !chop_swap;
    endproperty
    a_rst_release: assert property (p_rst_release)
        else $error("outputs not at reset state on release");

    // Back-to-back writes may stretch the pulse, so only the last counts.
    property p_cfg_restart;
        reg_wstrb && (reg_addr == 4'h0 || reg_addr == 4'h4) ##1
        !(reg_wstrb && (reg_addr == 4'h0 || reg_addr == 4'h4)) |->
            modulator_reset ##1 !modulator_reset;
    endproperty
    a_cfg_restart: assert property (p_cfg_restart)
        else $error("restart pulse missing or not one cycle");

    property p_no_spurious;
        !reg_wstrb && !modulator_reset |=> !modulator_reset;
    endproperty
    a_no_spurious: assert property (p_no_spurious)
        else $error("modulator reset without a restart");

    property p_hold;
        result_valid && !result_ready |=>
            result_valid && $stable(result_data);
    endproperty
    a_hold: assert property (p_hold)
        else $error("result dropped or changed while stalled");

    // A restarted filter needs a full conversion before any new word.
    property p_quiet;
        modulator_reset && !result_valid |=> !result_valid [*8];
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("result right after restart");

    property p_swap_restart;
        modulator_reset |=> !chop_swap;
    endproperty
    a_swap_restart: assert property (p_swap_restart)
        else $error("polarity not cleared by restart");
endmodule

bind sfs_filter sfs_filter_chk u_chk (
    .mclk(mclk), .reset(reset), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wstrb(reg_wstrb), .reg_rstrb(reg_rstrb),
    .reg_rdata(reg_rdata), .mod_bit(mod_bit),
    .modulator_reset(modulator_reset), .chop_swap(chop_swap),
    .result_valid(result_valid), .result_ready(result_ready),
    .result_data(result_data)
);

// ===== sfs_readout_model.sv
// Far side of the filter: modulator bit source and result readout.
// Assumes the filter synchronises mod_bit and holds words until ready.
`timescale 1ns/100ps

module sfs_readout_model
(
    input wire logic                  mclk,
    input wire logic                  level,
    input wire logic                  stall,
    input wire logic                  result_valid,
    input wire sfs_pkg::sfs_result_s  result_data,
    output logic                      mod_bit,
    output logic                      result_ready,
    output int                        n_got
);
    import sfs_pkg::*;

    initial begin
        mod_bit = 1'b0;
        n_got = 0;
    end

    // A stalled reader refuses words; the filter must keep them.
    assign result_ready = !stall;

    // Bitstream follows the commanded level; accepted words are counted.
    always @(posedge mclk) begin
        mod_bit <= level;
        if (result_valid && result_ready) begin
            n_got <= n_got + 1;
        end
    end
endmodule

// ===== testbench.sv
// Self-checking bench for the decimation filter control block.
// Assumes the design, package, checker and readout model are compiled.
`timescale 1ns/100ps

module testbench;
    import sfs_pkg::*;

    logic         mclk;
    logic         reset;
    logic         reg_wstrb;
    logic         reg_rstrb;
    logic         level;
    logic         stall;
    logic [3:0]   reg_addr;
    logic [31:0]  reg_wdata;
    logic [31:0]  reg_rdata;
    logic [31:0]  rd;
    logic         mod_bit;
    logic         modulator_reset;
    logic         chop_swap;
    logic         result_valid;
    logic         result_ready;
    sfs_result_s  result_data;
    int           err_count;
    int           n_compared;
    int           n;
    int           n_got;
    int           got0;
    int           av;
    int           len;

    sfs_filter dut (
        .mclk(mclk), .reset(reset), .ce(1'b1), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wstrb(reg_wstrb), .reg_rstrb(reg_rstrb),
        .reg_rdata(reg_rdata), .mod_bit(mod_bit),
        .modulator_reset(modulator_reset), .chop_swap(chop_swap),
        .result_valid(result_valid), .result_ready(result_ready),
        .result_data(result_data)
    );

    sfs_readout_model u_far (
        .mclk(mclk), .level(level), .stall(stall),
        .result_valid(result_valid), .result_data(result_data),
        .mod_bit(mod_bit), .result_ready(result_ready), .n_got(n_got)
    );

    // 40 MHz master clock.
    always #12.5 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wstrb <= 1'b1;
        @(posedge mclk);
        reg_wstrb <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe.
    task automatic rdreg(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rstrb <= 1'b1;
        @(posedge mclk);
        reg_rstrb <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Counts edges until the next word shows; a hang ends the run.
    task automatic wait_res(input int lim, output int cnt);
        cnt = 0;
        do begin
            @(posedge mclk);
            #1;
            cnt++;
        end while (result_valid !== 1'b1 && cnt < lim);
        if (result_valid !== 1'b1) begin
            err_count++;
            $display("CHECK FAILED result wait expected word seen none");
            give_verdict();
        end
    endtask

    task automatic near(input string what, input int cnt, input int exp);
        check(what, 32'(cnt >= exp && cnt <= exp + 6), 32'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        reset = 1'b1;
        reg_wstrb = 1'b0;
        reg_rstrb = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        level = 1'b1;
        stall = 1'b0;
        err_count = 0;
        n_compared = 0;
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        // Reset values, read-only and unmapped places, rate word limit.
        rdreg(4'h0, rd);
        check("config reset", rd, 32'h0000_1060);
        rdreg(4'h4, rd);
        check("channel reset", rd, 32'h0);
        rdreg(4'h2, rd);
        check("unmapped read", rd, 32'h0);
        wr(4'h8, 32'hffff_ffff);
        wr(4'h0, 32'h0000_13ff);
        rdreg(4'h0, rd);
        check("rate word max", rd, 32'h0000_13ff);
        // Chopped single-stage mode, rate word 1.
        len = 3 * 1024;
        wr(4'h0, 32'h0000_1001);
        wait_res(2 * len + 20, n);
        near("chop settle", n, 2 * len);
        check("chop offset", 32'(result_data.data), 32'h0);
        wait_res(len + 20, n);
        check("chop period", n, len);
        check("chop polarity", {31'h0, chop_swap}, 32'h1);
        // Channel change restarts and settles again.
        wr(4'h4, 32'h0000_0003);
        wait_res(2 * len + 20, n);
        near("channel settle", n, 2 * len);
        check("channel tag", 32'(result_data.channel), 32'h3);
        // Extra rejection keeps the chopped timing.
        wr(4'h0, 32'h0000_3001);
        wait_res(2 * len + 20, n);
        near("notch settle", n, 2 * len);
        // Fast settling, every averaging code, chop off.
        for (int s = 1; s < 4; s++) begin
            av = (s == 1) ? 2 : (s == 2) ? 8 : 16;
            len = (3 + av) * 1024;
            wr(4'h0, 32'h0000_0001 | (32'(s) << 10));
            wait_res(len + 20, n);
            near("fast settle", n, len);
            check("fast sign", {30'h0, result_data.data[27],
                                |result_data.data}, 32'h1);
            if (s == 1) begin
                wait_res(len + 20, n);
                check("fast period", n, len);
                rdreg(4'hc, rd);
                check("fast result", rd, 32'(len));
            end
        end
        // Fast settling by 2 with chop: same period, two-period settle.
        len = 5 * 1024;
        wr(4'h0, 32'h0000_1401);
        wait_res(2 * len + 20, n);
        near("fast chop settle", n, 2 * len);
        wait_res(len + 20, n);
        check("fast chop period", n, len);
        // Stalled reader: two words buffered, third held, none lost.
        len = 3 * 1024;
        @(posedge mclk);
        stall <= 1'b1;
        wr(4'h0, 32'h0000_1001);
        // Counted only now, after the last word before the stall is taken.
        got0 = n_got;
        repeat (4 * len + 100) @(posedge mclk);
        rdreg(4'h8, rd);
        check("held and valid", {30'h0, rd[1:0]}, 32'h3);
        @(posedge mclk);
        stall <= 1'b0;
        repeat (10) @(posedge mclk);
        check("words after stall", n_got - got0, 3);
        give_verdict();
    end
endmodule
